//--- rtl/tfa_pkg.sv
// Package with register map, field layout, modes and timing constants
package tfa_pkg;

  // Register byte offsets
  localparam logic [7:0] TFA_REG_CONFIG = 8'h00;
  localparam logic [7:0] TFA_REG_STATUS = 8'h04;
  localparam logic [7:0] TFA_REG_TXDATA = 8'h08;

  // Configuration field positions
  localparam int TFA_CFG_MODE_LSB   = 0;
  localparam int TFA_CFG_EDGE_BIT   = 2;
  localparam int TFA_CFG_FLY_BIT    = 3;
  localparam int TFA_CFG_TRI_BIT    = 4;
  localparam int TFA_CFG_ENABLE_BIT = 5;
  localparam logic [31:0] TFA_CFG_RESET = 32'h0000_0000;

  // Frame geometry, in bits
  localparam logic [9:0] TFA_T1_FRAME_BITS   = 10'h0c1;
  localparam logic [9:0] TFA_E1_FRAME_BITS   = 10'h100;
  localparam logic [9:0] TFA_NX64_FRAME_BITS = 10'h100;
  localparam logic [9:0] TFA_NX64_DELAY      = 10'h004;

  // Line clock limit and the AXI response codes
  localparam real TFA_LINE_CLK_MAX_MHZ = 8.192;
  localparam logic [1:0] TFA_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TFA_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TFA_MODE_T1   = 2'h0,
    TFA_MODE_E1   = 2'h1,
    TFA_MODE_NX64 = 2'h2
  } tfa_mode_t;

  typedef struct packed {
    logic      enable;
    logic      tristate_unmapped;
    logic      flywheel;
    logic      sync_on_falling;
    tfa_mode_t mode;
  } tfa_cfg_t;

  typedef struct packed {
    logic       in_frame;
    logic [9:0] bit_pos;
  } tfa_stat_t;

endpackage

//--- rtl/tfa_tx_frame_align.sv
// Transmit frame alignment for one serial port with AXI4-Lite control
`timescale 1ns/10ps
`default_nettype none

module tfa_tx_frame_align
  import tfa_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        tx_line_clock,
  input  wire logic        tx_frame_sync,
  output logic             tx_serial_data,
  output logic             tx_serial_data_oe
);

  // Register side state
  tfa_cfg_t    cfg;
  logic [31:0] tx_word;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  function automatic logic [9:0] frame_len(input tfa_mode_t m);
    case (m)
      TFA_MODE_T1:   frame_len = TFA_T1_FRAME_BITS;
      TFA_MODE_E1:   frame_len = TFA_E1_FRAME_BITS;
      default:       frame_len = TFA_NX64_FRAME_BITS;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a[7:2] == off[7:2]);
  endfunction

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (aw_held && w_held) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg          <= tfa_cfg_t'(TFA_CFG_RESET[5:0]);
      tx_word      <= 32'hffff_ffff;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TFA_RESP_OKAY;
    end else if (aw_held && w_held) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= TFA_RESP_OKAY;
      if (reg_hit(aw_addr, TFA_REG_CONFIG)) begin
        if (w_strb[0]) begin
          cfg <= tfa_cfg_t'(w_data[5:0]);
        end
      end else if (reg_hit(aw_addr, TFA_REG_TXDATA)) begin
        for (int i = 0; i < 4; i++) begin
          if (w_strb[i]) begin
            tx_word[i*8 +: 8] <= w_data[i*8 +: 8];
          end
        end
      end else if (!reg_hit(aw_addr, TFA_REG_STATUS)) begin
        s_axi_bresp <= TFA_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Link side state on the line clock, and its status copy on the register clock
  logic       cfg_edge_sel;
  tfa_stat_t  stat_link;
  tfa_stat_t  stat_ref;

  // Read channel: one cycle to answer
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= TFA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= TFA_RESP_OKAY;
      if (reg_hit(s_axi_araddr[7:0], TFA_REG_CONFIG)) begin
        s_axi_rdata <= {26'h0, cfg};
      end else if (reg_hit(s_axi_araddr[7:0], TFA_REG_STATUS)) begin
        s_axi_rdata <= {21'h0, stat_ref};
      end else if (reg_hit(s_axi_araddr[7:0], TFA_REG_TXDATA)) begin
        s_axi_rdata <= tx_word;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= TFA_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Status snapshot handed to the register clock by a toggle handshake
  logic       snap_req;
  logic       snap_req_q1;
  logic       snap_req_link;
  logic       snap_ack;
  logic       snap_ack_q1;
  logic       snap_ack_ref;
  tfa_stat_t  stat_hold;

  // Hold word is stable whenever the returned toggle matches the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap_req     <= 1'b0;
      snap_ack_q1  <= 1'b0;
      snap_ack_ref <= 1'b0;
      stat_ref     <= '0;
    end else begin
      snap_ack_q1  <= snap_ack;
      snap_ack_ref <= snap_ack_q1;
      if (snap_ack_ref == snap_req) begin
        stat_ref <= stat_hold;
        snap_req <= !snap_req;
      end
    end
  end

  always_ff @(posedge tx_line_clock) begin
    snap_req_q1   <= snap_req;
    snap_req_link <= snap_req_q1;
  end

  always_ff @(posedge tx_line_clock) begin
    if (link_rst) begin
      snap_ack  <= 1'b0;
      stat_hold <= '0;
    end else if (snap_req_link != snap_ack) begin
      snap_ack  <= snap_req_link;
      stat_hold <= stat_link;
    end
  end

  // Configuration and pattern into the link clock, two flops
  logic       link_rst_q1;
  logic       link_rst;
  tfa_cfg_t   cfg_q1;
  tfa_cfg_t   cfg_link;
  logic [31:0] word_q1;
  logic [31:0] word_link;

  always_ff @(posedge tx_line_clock) begin
    link_rst_q1 <= rst;
    link_rst    <= link_rst_q1;
    cfg_q1      <= cfg;
    cfg_link    <= cfg_q1;
    word_q1     <= tx_word;
    word_link   <= word_q1;
  end

  assign cfg_edge_sel = cfg_link.sync_on_falling;

  // Sync sampled on both edges; the selected one is used
  logic sync_rise_smp;
  logic sync_fall_smp;
  logic sync_prev;
  logic sync_now;
  logic sync_start;

  always_ff @(posedge tx_line_clock) begin
    sync_rise_smp <= tx_frame_sync;
  end

  always_ff @(negedge tx_line_clock) begin
    sync_fall_smp <= tx_frame_sync;
  end

  assign sync_now   = cfg_edge_sel ? sync_fall_smp : sync_rise_smp;

  always_ff @(posedge tx_line_clock) begin
    if (link_rst) begin
      sync_prev <= 1'b1;
    end else begin
      sync_prev <= sync_now;
    end
  end

  assign sync_start = sync_now && !sync_prev && cfg_link.enable;

  // Bit position counter and the Nx64 lead-in
  logic [9:0] bit_pos;
  logic [9:0] next_bit_pos;
  logic       in_frame;
  logic [2:0] lead_cnt;
  logic [2:0] lead_load;
  logic       frame_wrap;

  always_comb begin
    case (cfg_link.mode)
      TFA_MODE_NX64: lead_load = TFA_NX64_DELAY[2:0];
      default:       lead_load = 3'h0;
    endcase
    frame_wrap = (bit_pos == frame_len(cfg_link.mode) - 10'h001);
    if (frame_wrap) begin
      next_bit_pos = 10'h000;
    end else begin
      next_bit_pos = bit_pos + 10'h001;
    end
  end

  // Lead-in bits are counted apart so later Nx64 frames keep all their bits
  always_ff @(posedge tx_line_clock) begin
    if (link_rst) begin
      bit_pos  <= 10'h000;
      in_frame <= 1'b0;
      lead_cnt <= 3'h0;
    end else if (sync_start) begin
      bit_pos  <= 10'h000;
      in_frame <= 1'b1;
      lead_cnt <= lead_load;
    end else if (!cfg_link.enable) begin
      in_frame <= 1'b0;
      lead_cnt <= 3'h0;
    end else if (lead_cnt != 3'h0) begin
      lead_cnt <= lead_cnt - 3'h1;
    end else if (in_frame) begin
      bit_pos <= next_bit_pos;
      if (frame_wrap && !cfg_link.flywheel) begin
        in_frame <= 1'b0;
      end else begin
        in_frame <= 1'b1;
      end
    end
  end

  assign stat_link = '{in_frame: in_frame, bit_pos: bit_pos};

  // Bit launched at this edge: mapped or not, and its frame position
  logic       launch_mapped;
  logic [9:0] launch_pos;

  always_comb begin
    launch_mapped = 1'b0;
    launch_pos    = 10'h000;
    if (sync_start) begin
      launch_mapped = (cfg_link.mode != TFA_MODE_NX64);
    end else if (cfg_link.enable && in_frame) begin
      if (lead_cnt == 3'h1) begin
        launch_mapped = 1'b1;
      end else if (lead_cnt == 3'h0) begin
        launch_mapped = cfg_link.flywheel || !frame_wrap;
        launch_pos    = next_bit_pos;
      end
    end
  end

  // Launch on the line clock; frame bit zero is pattern bit 31
  always_ff @(posedge tx_line_clock) begin
    if (link_rst) begin
      tx_serial_data    <= 1'b1;
      tx_serial_data_oe <= 1'b0;
    end else if (launch_mapped) begin
      tx_serial_data    <= word_link[5'h1f - launch_pos[4:0]];
      tx_serial_data_oe <= 1'b1;
    end else begin
      tx_serial_data    <= 1'b1;
      tx_serial_data_oe <= !cfg_link.tristate_unmapped;
    end
  end

endmodule

`default_nettype wire

//--- verification/tfa_far_end.sv
// Far-side framer model: line clock and frame sync
`timescale 1ns/10ps
`default_nettype none
module tfa_far_end (
  output logic tx_line_clock,
  output logic tx_frame_sync
);
  initial begin
    tx_line_clock = 1'b0;
    tx_frame_sync = 1'b0;
    #7;
    forever #40 tx_line_clock = ~tx_line_clock;
  end
  // Raise sync a quarter into the high phase, return at the detecting rising edge
  task automatic send_sync();
    @(posedge tx_line_clock);
    #10 tx_frame_sync = 1'b1;
    @(posedge tx_line_clock);
    fork
      begin
        @(posedge tx_line_clock);
        #10 tx_frame_sync = 1'b0;
      end
    join_none
  endtask
endmodule
`default_nettype wire

//--- verification/tfa_tx_frame_align_sva.sv
// Checker for bus handshakes and line output timing
`timescale 1ns/10ps
`default_nettype none
module tfa_tx_frame_align_sva
  import tfa_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_line_clock,
  input wire logic        tx_serial_data,
  input wire logic        tx_serial_data_oe
);
  logic [1:0] mid;
  logic [1:0] link_settle;
  always_ff @(negedge tx_line_clock) mid <= {tx_serial_data, tx_serial_data_oe};
  // Link side leaves reset a few line edges after the register side
  always_ff @(posedge tx_line_clock) begin
    if (rst) link_settle <= 2'h0;
    else if (link_settle != 2'h3) link_settle <= link_settle + 2'h1;
  end
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_both |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  bv_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rd_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_taken |=> s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_refuse_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  err_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    s_axi_rvalid && s_axi_rresp == TFA_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read data not zero");
  launch_edge_a: assert property (@(posedge tx_line_clock)
    disable iff (rst || link_settle != 2'h3)
    {tx_serial_data, tx_serial_data_oe} == mid) else $error("output moved off edge");
endmodule
bind tfa_tx_frame_align tfa_tx_frame_align_sva i_sva (.ref_clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .tx_line_clock, .tx_serial_data, .tx_serial_data_oe);
`default_nettype wire

//--- verification/tfa_tx_frame_align_test.sv
// Self-checking bench for the transmit frame alignment block
`timescale 1ns/10ps
`default_nettype none
module tfa_tx_frame_align_test
  import tfa_pkg::*;
;
  logic        ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, line_clk, sync, sdata, soe;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_val, pat, seed;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp, e;
  logic [5:0]  cfg;
  int          miscompares, check_count;
  tfa_tx_frame_align i_dut (.ref_clk, .rst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_line_clock(line_clk), .tx_frame_sync(sync), .tx_serial_data(sdata),
    .tx_serial_data_oe(soe));
  tfa_far_end i_far (.tx_line_clock(line_clk), .tx_frame_sync(sync));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Expected {oe, data} for bit period k after the detecting edge
  function automatic logic [1:0] exp_bit(input int k);
    int len;
    int b;
    len = int'(cfg[1:0] == TFA_MODE_T1 ? TFA_T1_FRAME_BITS :
               cfg[1:0] == TFA_MODE_E1 ? TFA_E1_FRAME_BITS : TFA_NX64_FRAME_BITS);
    b = k - ((cfg[1:0] == TFA_MODE_NX64) ? int'(TFA_NX64_DELAY) : 0);
    if (b < 0 || (b >= len && !cfg[3]))
      return cfg[4] ? 2'b00 : 2'b11;
    return {1'b1, pat[31 - (b % len) % 32]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr_resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_val = rdata;
    rd_resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic complete_run();
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    complete_run();
  end
  initial begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    miscompares = 0;
    check_count = 0;
    seed = 32'h8205;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    axi_rd(TFA_REG_CONFIG);
    chk(rd_val, TFA_CFG_RESET);
    axi_rd(TFA_REG_TXDATA);
    chk(rd_val, 32'hffff_ffff);
    axi_rd(8'h0c);
    chk(rd_val, 32'h0);
    chk({30'h0, rd_resp}, {30'h0, TFA_RESP_SLVERR});
    axi_wr(8'h0c, 32'h0);
    chk({30'h0, wr_resp}, {30'h0, TFA_RESP_SLVERR});
    for (int s = 0; s < 6; s++) begin
      seed = lfsr(seed);
      pat = seed;
      cfg = {1'b0, seed[7], s[0], (s > 2), 2'(s % 3)};
      axi_wr(TFA_REG_CONFIG, {26'h0, cfg});
      chk({30'h0, wr_resp}, {30'h0, TFA_RESP_OKAY});
      axi_wr(TFA_REG_TXDATA, pat);
      axi_rd(TFA_REG_TXDATA);
      chk(rd_val, pat);
      // Disabled port shows no frame once the snapshot has caught up
      repeat (8) @(posedge line_clk);
      axi_rd(TFA_REG_STATUS);
      chk({31'h0, rd_val[10]}, 32'h0);
      axi_wr(TFA_REG_CONFIG, {26'h0, cfg | 6'h20});
      repeat (4) @(posedge line_clk);
      i_far.send_sync();
      // A rising-edge sample is acted on at the following rising edge
      if (!cfg[2]) @(posedge line_clk);
      for (int k = 0; k < 200; k++) begin
        @(negedge line_clk);
        e = exp_bit(k);
        chk({30'h0, soe, soe & sdata}, {30'h0, e[1], &e});
      end
      // Only a T1 frame without flywheel has ended by now
      repeat (8) @(posedge line_clk);
      axi_rd(TFA_REG_STATUS);
      chk({31'h0, rd_val[10]}, {31'h0, cfg[3] || (cfg[1:0] != TFA_MODE_T1)});
      axi_wr(TFA_REG_CONFIG, {26'h0, cfg});
    end
    complete_run();
  end
endmodule
`default_nettype wire
